// [gfa_top.sv]
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps

module gfa_top
  import gfa_pkg::*;
#(
  parameter int BIN_W = gfa_pkg::BIN_W_DEF
) (
  input  wire logic                      REF_CLK_I,
  input  wire logic                      SYS_RST_I,
  input  wire logic [gfa_pkg::ADDR_W-1:0] AXI_AWADDR_I,
  input  wire logic                      AXI_AWVALID_I,
  output logic                           AXI_AWREADY_O,
  input  wire logic [31:0]               AXI_WDATA_I,
  input  wire logic [3:0]                AXI_WSTRB_I,
  input  wire logic                      AXI_WVALID_I,
  output logic                           AXI_WREADY_O,
  output logic [1:0]                     AXI_BRESP_O,
  output logic                           AXI_BVALID_O,
  input  wire logic                      AXI_BREADY_I,
  input  wire logic [gfa_pkg::ADDR_W-1:0] AXI_ARADDR_I,
  input  wire logic                      AXI_ARVALID_I,
  output logic                           AXI_ARREADY_O,
  output logic [31:0]                    AXI_RDATA_O,
  output logic [1:0]                     AXI_RRESP_O,
  output logic                           AXI_RVALID_O,
  input  wire logic                      AXI_RREADY_I
);
  import gfa_pkg::*;

  localparam int BCD_D = OP_W / 4;

  // Bus slave state
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic              aw_hold, next_aw_hold;
  logic [31:0]       w_data, next_w_data;
  logic [3:0]        w_strb, next_w_strb;
  logic              w_hold, next_w_hold;
  logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [31:0]       next_rdata;
  logic              wr_fire;
  logic [31:0]       wmask;

  // Software registers
  logic [CTRL_W-1:0]   ctrl, next_ctrl;
  logic [OP_W-1:0]     opx, next_opx;
  logic [OP_W-1:0]     opy, next_opy;
  logic [CELLIN_W-1:0] cell_in, next_cell_in;
  logic                start_bin, next_start_bin;
  logic                start_bcd, next_start_bcd;

  // Serial datapath state
  gfa_state_e      state, next_state;
  logic [OP_W-1:0] sx, next_sx;
  logic [OP_W-1:0] sy, next_sy;
  logic [OP_W-1:0] res, next_res;
  logic [3:0]      wx, next_wx;
  logic [3:0]      wy, next_wy;
  logic [3:0]      cnt, next_cnt;
  logic [1:0]      div4, next_div4;
  logic            carry, next_carry;
  logic            done, next_done;

  // Cell outputs
  logic       bin_sum, bin_co_n;
  logic       t_sum, t_sum_n, t_co_n;
  logic [3:0] dx, dy, ax, ay;
  logic [3:0] ch_cin, ch_sum, ch_co_n, ch_s, ch_sn;
  logic [4:0] bin5, adj_sum;
  logic       adj;

  // Serial binary bit cell: subtrahend inverted by the mode bit
  gfa_cell u_bin (
    .x_true_in_a_i        (sx[0]),
    .x_true_in_b_i        (1'b1),
    .x_comp_n_i           (1'b1),
    .x_gate_control_i     (1'b1),
    .y_true_in_a_i        (sy[0] ^ ctrl[CTRL_ADD_SUB]),
    .y_true_in_b_i        (1'b1),
    .y_comp_n_i           (1'b1),
    .y_gate_control_i     (1'b1),
    .carry_input_i        (carry),
    .sum_o                (bin_sum),
    .sum_n_o              (),
    .carry_out_inverted_o (bin_co_n)
  );

  // Software-driven cell for direct exercise of the gating
  gfa_cell u_test (
    .x_true_in_a_i        (cell_in[CI_XA]),
    .x_true_in_b_i        (cell_in[CI_XB]),
    .x_comp_n_i           (cell_in[CI_XCN]),
    .x_gate_control_i     (cell_in[CI_XG]),
    .y_true_in_a_i        (cell_in[CI_YA]),
    .y_true_in_b_i        (cell_in[CI_YB]),
    .y_comp_n_i           (cell_in[CI_YCN]),
    .y_gate_control_i     (cell_in[CI_YG]),
    .carry_input_i        (cell_in[CI_CARRY]),
    .sum_o                (t_sum),
    .sum_n_o              (t_sum_n),
    .carry_out_inverted_o (t_co_n)
  );

  // Digit assembly and nine's-complement converters (control low complements)
  always_comb begin
    dx = {sx[0], wx[3:1]};
    dy = {sy[0], wy[3:1]};
    ax = ctrl[CTRL_CONV_X] ? dx : NINE - dx;
    ay = ctrl[CTRL_CONV_Y] ? dy : NINE - dy;
  end

  // Four-bit ripple with alternating polarity saves an inverter per carry hop
  assign ch_cin = {ch_co_n[2:0], carry};
  for (genvar i = 0; i < 4; i++) begin : g_rip
    if (i % 2 == 0) begin : g_true
      gfa_cell u_c (
        .x_true_in_a_i        (ax[i]),
        .x_true_in_b_i        (1'b1),
        .x_comp_n_i           (1'b1),
        .x_gate_control_i     (1'b1),
        .y_true_in_a_i        (ay[i]),
        .y_true_in_b_i        (1'b1),
        .y_comp_n_i           (1'b1),
        .y_gate_control_i     (1'b1),
        .carry_input_i        (ch_cin[i]),
        .sum_o                (ch_s[i]),
        .sum_n_o              (ch_sn[i]),
        .carry_out_inverted_o (ch_co_n[i])
      );
      assign ch_sum[i] = ch_s[i];
    end else begin : g_comp
      gfa_cell u_c (
        .x_true_in_a_i        (1'b0),
        .x_true_in_b_i        (1'b0),
        .x_comp_n_i           (ax[i]),
        .x_gate_control_i     (1'b1),
        .y_true_in_a_i        (1'b0),
        .y_true_in_b_i        (1'b0),
        .y_comp_n_i           (ay[i]),
        .y_gate_control_i     (1'b1),
        .carry_input_i        (ch_cin[i]),
        .sum_o                (ch_s[i]),
        .sum_n_o              (ch_sn[i]),
        .carry_out_inverted_o (ch_co_n[i])
      );
      assign ch_sum[i] = ch_sn[i];
    end
  end

  // Decimal correction of the binary digit sum
  always_comb begin
    bin5    = {ch_co_n[3], ch_sum};
    adj     = bin5 > BCD_MAX;
    adj_sum = bin5 + BCD_ADJ;
  end

  // Write byte-lane mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{w_strb[b]}};
    end
  end

  // Bus slave: address and data taken in either order, answer after both
  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold  = w_hold;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = AXI_BVALID_O;
    next_bresp   = AXI_BRESP_O;
    wr_fire      = aw_hold & w_hold & ~AXI_BVALID_O;
    if (AXI_AWVALID_I && AXI_AWREADY_O) begin
      next_aw_hold = 1'b1;
      next_aw_addr = AXI_AWADDR_I;
    end
    if (AXI_WVALID_I && AXI_WREADY_O) begin
      next_w_hold = 1'b1;
      next_w_data = AXI_WDATA_I;
      next_w_strb = AXI_WSTRB_I;
    end
    if (AXI_BVALID_O && AXI_BREADY_I) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_addr[ADDR_W-1:5] == '0) ? RESP_OKAY : RESP_SLVERR;
    end
    next_awready = ~next_aw_hold & ~next_bvalid;
    next_wready  = ~next_w_hold & ~next_bvalid;
  end

  // Register writes; command bits make one-cycle start pulses
  always_comb begin
    next_ctrl      = ctrl;
    next_opx       = opx;
    next_opy       = opy;
    next_cell_in   = cell_in;
    next_start_bin = 1'b0;
    next_start_bcd = 1'b0;
    if (wr_fire) begin
      case (aw_addr)
        OFF_CTRL:   next_ctrl = (ctrl & ~wmask[CTRL_W-1:0])
                                | (w_data[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
        OFF_OPX:    next_opx = (opx & ~wmask[OP_W-1:0]) | (w_data[OP_W-1:0] & wmask[OP_W-1:0]);
        OFF_OPY:    next_opy = (opy & ~wmask[OP_W-1:0]) | (w_data[OP_W-1:0] & wmask[OP_W-1:0]);
        OFF_CELLIN: next_cell_in = (cell_in & ~wmask[CELLIN_W-1:0])
                                   | (w_data[CELLIN_W-1:0] & wmask[CELLIN_W-1:0]);
        OFF_CMD: begin
          next_start_bin = w_strb[0] & w_data[CMD_START_BIN];
          next_start_bcd = w_strb[0] & w_data[CMD_START_BCD];
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel: one request at a time, data registered
  always_comb begin
    next_rvalid = AXI_RVALID_O;
    next_rdata  = AXI_RDATA_O;
    next_rresp  = AXI_RRESP_O;
    if (AXI_RVALID_O && AXI_RREADY_I) begin
      next_rvalid = 1'b0;
    end
    if (AXI_ARVALID_I && AXI_ARREADY_O) begin
      next_rvalid = 1'b1;
      next_rresp  = (AXI_ARADDR_I[ADDR_W-1:5] == '0) ? RESP_OKAY : RESP_SLVERR;
      next_rdata  = 32'h0000_0000;
      case (AXI_ARADDR_I & 8'hfc)
        OFF_CTRL:    next_rdata[CTRL_W-1:0] = ctrl;
        OFF_OPX:     next_rdata[OP_W-1:0] = opx;
        OFF_OPY:     next_rdata[OP_W-1:0] = opy;
        OFF_RESULT:  next_rdata[OP_W-1:0] = res;
        OFF_STATUS: begin
          next_rdata[STAT_BUSY]  = (state != ST_IDLE);
          next_rdata[STAT_DONE]  = done;
          next_rdata[STAT_CARRY] = carry;
        end
        OFF_CELLIN:  next_rdata[CELLIN_W-1:0] = cell_in;
        OFF_CELLOUT: begin
          next_rdata[CO_SUM]    = t_sum;
          next_rdata[CO_SUM_N]  = t_sum_n;
          next_rdata[CO_CARRYN] = t_co_n;
        end
        default: begin
        end
      endcase
    end
    next_arready = ~next_rvalid;
  end

  // Serial sequencer; starts while busy are ignored
  always_comb begin
    next_state = state;
    next_sx    = sx;
    next_sy    = sy;
    next_res   = res;
    next_wx    = wx;
    next_wy    = wy;
    next_cnt   = cnt;
    next_div4  = div4;
    next_carry = carry;
    next_done  = done;
    case (state)
      ST_IDLE: begin
        if (start_bin) begin
          next_state = ST_BIN;
          next_sx    = opx;
          next_sy    = opy;
          next_res   = '0;
          next_cnt   = 4'(BIN_W);
          next_carry = ctrl[CTRL_ADD_SUB];
          next_done  = 1'b0;
        end else if (start_bcd) begin
          next_state = ST_BCD;
          next_sx    = opx;
          next_sy    = opy;
          next_res   = '0;
          next_wx    = 4'h0;
          next_wy    = 4'h0;
          next_cnt   = 4'(BCD_D);
          next_div4  = DIV4_INIT;
          next_carry = ctrl[CTRL_BCD_CARRY];
          next_done  = 1'b0;
        end
      end
      ST_BIN: begin
        // LSB first; sum enters at the top and walks toward bit 0
        next_sx             = sx >> 1;
        next_sy             = sy >> 1;
        next_res            = res >> 1;
        next_res[BIN_W-1]   = bin_sum;
        next_carry          = ~bin_co_n;
        next_cnt            = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_state = ST_IDLE;
          next_done  = 1'b1;
        end
      end
      ST_BCD: begin
        next_sx   = sx >> 1;
        next_sy   = sy >> 1;
        next_wx   = dx;
        next_wy   = dy;
        next_div4 = div4 - 2'h1;
        if (div4 == 2'h0) begin
          next_res   = {adj ? adj_sum[3:0] : bin5[3:0], res[OP_W-1:4]};
          next_carry = adj;
          next_cnt   = cnt - 4'h1;
          if (cnt == 4'h1) begin
            next_state = ST_IDLE;
            next_done  = 1'b1;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Everything registers on the one system clock edge
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      AXI_AWREADY_O <= 1'b0;
      AXI_WREADY_O <= 1'b0;
      AXI_BVALID_O <= 1'b0;
      AXI_BRESP_O <= RESP_OKAY;
      AXI_ARREADY_O <= 1'b0;
      AXI_RVALID_O <= 1'b0;
      AXI_RDATA_O <= 32'h0000_0000;
      AXI_RRESP_O <= RESP_OKAY;
      ctrl <= CTRL_RST;
      opx <= '0;
      opy <= '0;
      cell_in <= CELLIN_RST;
      start_bin <= 1'b0;
      start_bcd <= 1'b0;
      state <= ST_IDLE;
      sx <= '0;
      sy <= '0;
      res <= '0;
      wx <= 4'h0;
      wy <= 4'h0;
      cnt <= 4'h0;
      div4 <= DIV4_INIT;
      carry <= 1'b0;
      done <= 1'b0;
    end else begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold <= next_w_hold;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      AXI_AWREADY_O <= next_awready;
      AXI_WREADY_O <= next_wready;
      AXI_BVALID_O <= next_bvalid;
      AXI_BRESP_O <= next_bresp;
      AXI_ARREADY_O <= next_arready;
      AXI_RVALID_O <= next_rvalid;
      AXI_RDATA_O <= next_rdata;
      AXI_RRESP_O <= next_rresp;
      ctrl <= next_ctrl;
      opx <= next_opx;
      opy <= next_opy;
      cell_in <= next_cell_in;
      start_bin <= next_start_bin;
      start_bcd <= next_start_bcd;
      state <= next_state;
      sx <= next_sx;
      sy <= next_sy;
      res <= next_res;
      wx <= next_wx;
      wy <= next_wy;
      cnt <= next_cnt;
      div4 <= next_div4;
      carry <= next_carry;
      done <= next_done;
    end
  end

  // Checks on the test cell, ripple chain and sequencer
  property p_cell_sum;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (cell_in[CI_XG] && cell_in[CI_YG]) |-> (t_sum == (((cell_in[CI_XA] & cell_in[CI_XB])
      | ~cell_in[CI_XCN]) ^ ((cell_in[CI_YA] & cell_in[CI_YB]) | ~cell_in[CI_YCN])
      ^ cell_in[CI_CARRY])) && (t_sum_n == ~t_sum);
  endproperty
  a_cell_sum: assert property (p_cell_sum) else $error("cell sum wrong");
  property p_cell_carry;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (cell_in[CI_XG] && cell_in[CI_YG] && !cell_in[CI_XCN] && !cell_in[CI_YCN])
      |-> !t_co_n;
  endproperty
  a_cell_carry: assert property (p_cell_carry) else $error("carry out not low");
  property p_cell_gate;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      !(cell_in[CI_XG] && cell_in[CI_YG]) |-> !(t_sum || t_sum_n || t_co_n);
  endproperty
  a_cell_gate: assert property (p_cell_gate) else $error("disabled cell drives");
  property p_cell_block;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (cell_in[CI_XG] && cell_in[CI_YG] && cell_in[CI_XCN] && cell_in[CI_YCN]
       && !cell_in[CI_XB] && !cell_in[CI_YB] && !cell_in[CI_CARRY]) |-> !t_sum;
  endproperty
  a_cell_block: assert property (p_cell_block) else $error("blocked sum not zero");
  property p_cell_pass;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (cell_in[CI_XG] && cell_in[CI_YG] && cell_in[CI_XCN] && cell_in[CI_YCN]
       && cell_in[CI_XB] && cell_in[CI_YB])
      |-> t_sum == (cell_in[CI_XA] ^ cell_in[CI_YA] ^ cell_in[CI_CARRY]);
  endproperty
  a_cell_pass: assert property (p_cell_pass) else $error("true inputs not passed");
  property p_ripple;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == ST_BCD) |-> bin5 == (5'(ax) + 5'(ay) + 5'(carry));
  endproperty
  a_ripple: assert property (p_ripple) else $error("ripple chain sum wrong");
  property p_bin_len;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == ST_IDLE && start_bin) |=> (state == ST_BIN)[*4] ##1 (state == ST_IDLE && done);
  endproperty
  a_bin_len: assert property (p_bin_len) else $error("serial result late");
  property p_bin_init;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == ST_IDLE && start_bin) |=> carry == $past(ctrl[CTRL_ADD_SUB]);
  endproperty
  a_bin_init: assert property (p_bin_init) else $error("carry not set by mode");
  property p_div4_init;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == ST_IDLE && !start_bin && start_bcd) |=> div4 == DIV4_INIT ##3 div4 == 2'h0;
  endproperty
  a_div4_init: assert property (p_div4_init) else $error("counter not started at ones");
  property p_bcd_carry;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == ST_BCD && div4 != 2'h0) |=> $stable(carry);
  endproperty
  a_bcd_carry: assert property (p_bcd_carry) else $error("carry moved off quarter rate");
  property p_bcd_load;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (state == ST_BCD && div4 != 2'h0) |=> $stable(res);
  endproperty
  a_bcd_load: assert property (p_bcd_load) else $error("result loaded between digits");
endmodule

// [gfa_cell.sv]
`timescale 1ns/1ps

package gfa_pkg;
  // Datapath sizes
  localparam int OP_W      = 8;
  localparam int BIN_W_DEF = 4;
  localparam int ADDR_W    = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CMD     = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_OPX     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_OPY     = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_RESULT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CELLIN  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CELLOUT = 8'h1c;

  // Control fields
  localparam int CTRL_W         = 4;
  localparam int CTRL_ADD_SUB   = 0;
  localparam int CTRL_CONV_X    = 1;
  localparam int CTRL_CONV_Y    = 2;
  localparam int CTRL_BCD_CARRY = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;

  // Command and status fields
  localparam int CMD_START_BIN = 0;
  localparam int CMD_START_BCD = 1;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_DONE     = 1;
  localparam int STAT_CARRY    = 2;

  // Direct cell access fields
  localparam int CELLIN_W  = 9;
  localparam int CI_XA     = 0;
  localparam int CI_XB     = 1;
  localparam int CI_XCN    = 2;
  localparam int CI_XG     = 3;
  localparam int CI_YA     = 4;
  localparam int CI_YB     = 5;
  localparam int CI_YCN    = 6;
  localparam int CI_YG     = 7;
  localparam int CI_CARRY  = 8;
  localparam logic [CELLIN_W-1:0] CELLIN_RST = 9'h0cc;
  localparam int CO_SUM    = 0;
  localparam int CO_SUM_N  = 1;
  localparam int CO_CARRYN = 2;

  // BCD sequencing constants
  localparam logic [1:0] DIV4_INIT = 2'h3;
  localparam logic [3:0] NINE      = 4'h9;
  localparam logic [4:0] BCD_MAX   = 5'h09;
  localparam logic [4:0] BCD_ADJ   = 5'h06;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BIN  = 3'b010,
    ST_BCD  = 3'b100
  } gfa_state_e;
endpackage

module gfa_cell (
  input  wire logic x_true_in_a_i,
  input  wire logic x_true_in_b_i,
  input  wire logic x_comp_n_i,
  input  wire logic x_gate_control_i,
  input  wire logic y_true_in_a_i,
  input  wire logic y_true_in_b_i,
  input  wire logic y_comp_n_i,
  input  wire logic y_gate_control_i,
  input  wire logic carry_input_i,
  output logic      sum_o,
  output logic      sum_n_o,
  output logic      carry_out_inverted_o
);
  logic x_eff;
  logic y_eff;
  logic enable;
  logic parity;

  // Open complement pin reads high, so it ORs away; true pins low leave it alone
  always_comb begin
    x_eff  = (x_true_in_a_i & x_true_in_b_i) | ~x_comp_n_i;
    y_eff  = (y_true_in_a_i & y_true_in_b_i) | ~y_comp_n_i;
    enable = x_gate_control_i & y_gate_control_i;
    parity = x_eff ^ y_eff ^ carry_input_i;
  end

  // Disabled bit drives every output low so it can clear a storage register
  always_comb begin
    sum_o                = enable & parity;
    sum_n_o              = enable & ~parity;
    carry_out_inverted_o = enable & ~((x_eff & y_eff) | (x_eff & carry_input_i)
                                      | (y_eff & carry_input_i));
  end
endmodule

// [gfa_axi_host.sv]
`timescale 1ns/1ps
// Register-bus master standing in for software
module gfa_axi_host (
  input  wire logic        clk_i,
  output logic [7:0]       aw_addr_o,
  output logic             aw_valid_o,
  input  wire logic        aw_ready_i,
  output logic [31:0]      w_data_o,
  output logic [3:0]       w_strb_o,
  output logic             w_valid_o,
  input  wire logic        w_ready_i,
  input  wire logic [1:0]  b_resp_i,
  input  wire logic        b_valid_i,
  output logic             b_ready_o,
  output logic [7:0]       ar_addr_o,
  output logic             ar_valid_o,
  input  wire logic        ar_ready_i,
  input  wire logic [31:0] r_data_i,
  input  wire logic [1:0]  r_resp_i,
  input  wire logic        r_valid_i,
  output logic             r_ready_o
);
  // Idle bus at time zero
  initial begin
    {aw_addr_o, aw_valid_o, w_data_o, w_valid_o, b_ready_o} = '0;
    {ar_addr_o, ar_valid_o, r_ready_o} = '0;
    w_strb_o = 4'hf;
  end

  // Write: address and data offered together, released each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tw;
    @(posedge clk_i);
    aw_addr_o  <= a;
    w_data_o   <= d;
    aw_valid_o <= 1'h1;
    w_valid_o  <= 1'h1;
    ta = 1'h0;
    tw = 1'h0;
    while (!(ta && tw)) begin
      @(posedge clk_i);
      if (!ta && aw_ready_i) begin
        ta = 1'h1;
        aw_valid_o <= 1'h0;
        aw_addr_o  <= ~a; // Stale payload is not left looking valid
      end
      if (!tw && w_ready_i) begin
        tw = 1'h1;
        w_valid_o <= 1'h0;
        w_data_o  <= ~d;
      end
    end
    b_ready_o <= 1'h1;
    do @(posedge clk_i); while (b_valid_i !== 1'h1);
    r = b_resp_i;
    b_ready_o <= 1'h0;
  endtask

  // Read: ready for data from the start, wait for the answer
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    ar_addr_o  <= a;
    ar_valid_o <= 1'h1;
    r_ready_o  <= 1'h1;
    do @(posedge clk_i); while (ar_ready_i !== 1'h1);
    ar_valid_o <= 1'h0;
    ar_addr_o  <= ~a;
    do @(posedge clk_i); while (r_valid_i !== 1'h1);
    d = r_data_i;
    r = r_resp_i;
    r_ready_o <= 1'h0;
  endtask
endmodule

// [gfa_top_bench.sv]
`timescale 1ns/1ps
module gfa_top_bench;
  import gfa_pkg::*;
  logic        clk, rst;
  logic [7:0]  aw_addr, ar_addr;
  logic [31:0] w_data, r_data;
  logic [3:0]  w_strb;
  logic [1:0]  b_resp, r_resp;
  logic        aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
  logic        ar_valid, ar_ready, r_valid, r_ready;
  int          failures, check_count;

  gfa_top #(.BIN_W(4)) i_gfa_top (
    .REF_CLK_I(clk), .SYS_RST_I(rst),
    .AXI_AWADDR_I(aw_addr), .AXI_AWVALID_I(aw_valid), .AXI_AWREADY_O(aw_ready),
    .AXI_WDATA_I(w_data), .AXI_WSTRB_I(w_strb), .AXI_WVALID_I(w_valid),
    .AXI_WREADY_O(w_ready), .AXI_BRESP_O(b_resp), .AXI_BVALID_O(b_valid),
    .AXI_BREADY_I(b_ready), .AXI_ARADDR_I(ar_addr), .AXI_ARVALID_I(ar_valid),
    .AXI_ARREADY_O(ar_ready), .AXI_RDATA_O(r_data), .AXI_RRESP_O(r_resp),
    .AXI_RVALID_O(r_valid), .AXI_RREADY_I(r_ready));

  gfa_axi_host i_gfa_axi_host (
    .clk_i(clk), .aw_addr_o(aw_addr), .aw_valid_o(aw_valid), .aw_ready_i(aw_ready),
    .w_data_o(w_data), .w_strb_o(w_strb), .w_valid_o(w_valid), .w_ready_i(w_ready),
    .b_resp_i(b_resp), .b_valid_i(b_valid), .b_ready_o(b_ready),
    .ar_addr_o(ar_addr), .ar_valid_o(ar_valid), .ar_ready_i(ar_ready),
    .r_data_i(r_data), .r_resp_i(r_resp), .r_valid_i(r_valid), .r_ready_o(r_ready));

  // 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Register helpers; a good access must answer OKAY
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    i_gfa_axi_host.rd(a, d, r);
    chk("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
    chk(nm, d, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    i_gfa_axi_host.wr(a, d, r);
    chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  // Reset values, a read-only place and an unmapped address
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rchk(OFF_CTRL, 32'h0, "ctrl");
    rchk(OFF_CELLIN, 32'h0cc, "cellin");
    rchk(OFF_STATUS, 32'h0, "status");
    wr(OFF_RESULT, 32'ha5);
    rchk(OFF_RESULT, 32'h0, "result");
    i_gfa_axi_host.rd(8'h20, d, r);
    chk("bad rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    chk("bad rdata", d, 32'h0);
    i_gfa_axi_host.wr(8'h20, 32'h1, r);
    chk("bad bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
  endtask

  // Cell through true inputs, complement inputs, and with its gate shut
  task automatic t_cell();
    logic x, y, c, s, k, ss, ks;
    for (int i = 0; i < 8; i++) begin
      {c, y, x} = i[2:0];
      s = x ^ y ^ c;
      k = ~((x & y) | (x & c) | (y & c));
      ss = x ^ ~y ^ c;
      ks = ~((x & ~y) | (x & c) | (~y & c));
      wr(OFF_CELLIN, {23'h0, c, 3'h7, y, 3'h7, x});
      rchk(OFF_CELLOUT, {29'h0, k, ~s, s}, "true in");
      wr(OFF_CELLIN, {23'h0, c, 1'h1, ~y, 2'h0, 1'h1, ~x, 2'h0});
      rchk(OFF_CELLOUT, {29'h0, k, ~s, s}, "comp in");
      wr(OFF_CELLIN, {23'h0, c, 3'h7, y, 3'h3, x});
      rchk(OFF_CELLOUT, 32'h0, "gated");
      wr(OFF_CELLIN, {23'h0, c, 1'h1, y, 5'h07, x});
      rchk(OFF_CELLOUT, {29'h0, ks, ~ss, ss}, "sub cell");
      wr(OFF_CELLIN, {23'h0, c, 1'h0, y, 5'h06, x});
      rchk(OFF_CELLOUT, 32'h0, "sub gated");
    end
    wr(OFF_CELLIN, 32'h0dd);
    rchk(OFF_CELLOUT, 32'h6, "blocked");
  endtask

  // Start a serial run and poll until done, bounded
  task automatic run(input logic [31:0] ctl, input logic [31:0] cmd,
                     input logic [31:0] x, input logic [31:0] y, output logic [31:0] s);
    logic [1:0] r;
    int         n;
    wr(OFF_CTRL, ctl);
    wr(OFF_OPX, x);
    wr(OFF_OPY, y);
    wr(OFF_CMD, cmd);
    s = 32'h0;
    for (n = 0; n < 40 && s[STAT_DONE] !== 1'h1; n++) i_gfa_axi_host.rd(OFF_STATUS, s, r);
    chk("done", {31'h0, s[STAT_DONE]}, 32'h1);
  endtask

  // Binary add then subtract, with and without end carry
  task automatic t_bin();
    logic [3:0]  xs [3] = '{4'h3, 4'h9, 4'hf};
    logic [3:0]  ys [3] = '{4'h5, 4'h8, 4'h1};
    logic [3:0]  x, y;
    logic        sub;
    logic [4:0]  e;
    logic [31:0] s;
    for (int i = 0; i < 6; i++) begin
      x = xs[i % 3];
      y = ys[i % 3];
      sub = (i >= 3);
      e = sub ? {1'h0, x} + {1'h0, ~y} + 5'h1 : {1'h0, x} + {1'h0, y};
      run({31'h0, sub}, 32'h1, {28'h0, x}, {28'h0, y}, s);
      chk("bin status", s, {29'h0, e[4], 2'h2});
      rchk(OFF_RESULT, {28'h0, e[3:0]}, "bin result");
    end
  endtask

  // Two-digit decimal add, then subtract with the smaller operand converted
  task automatic t_bcd();
    logic [31:0] s;
    run(32'h6, 32'h2, 32'h45, 32'h38, s);
    chk("bcd add status", s, 32'h2);
    rchk(OFF_RESULT, 32'h83, "bcd add");
    run(32'ha, 32'h2, 32'h45, 32'h38, s);
    chk("bcd sub status", s, 32'h6);
    rchk(OFF_RESULT, 32'h07, "bcd sub");
    run(32'hc, 32'h2, 32'h38, 32'h45, s);
    chk("bcd rsub status", s, 32'h6);
    rchk(OFF_RESULT, 32'h07, "bcd rsub");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence: reset for six cycles, then every scenario
  initial begin
    rst = 1'h1;
    failures = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    t_regs();
    t_cell();
    t_bin();
    t_bcd();
    give_verdict();
  end

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule
